// >>> hdl/psm_power_save_ctrl.sv
// Behaviour
// - Light sleep gates CPU and system clocks; oscillator keeps running.
// - Setting the light-sleep bit by a store enters light sleep.
// - Light sleep halts execution and peripherals, keeps state, ignores hold.
// - Light sleep ends only on NMI or reset pin.
// - NMI wake services the NMI, unless slept inside the NMI handler.
// - NMI wake uses the ordinary single NMI vector.
// - Reset pin wake runs the ordinary system reset sequence.
// - Deep sleep stops CPU clock, system clock and oscillator.
// - Deep sleep halts execution and peripherals while keeping all state.
// - Stabilization wait follows deep sleep unless bypass and external clock.
// - NMI ending deep sleep is serviced, unless slept inside NMI handler.
// - NMI valid edge ends deep sleep; counter starts on inactive edge.
// - Count done restarts system clock and branches to NMI vector.
// - Deep request with pending NMI wakes at once, waiting if needed.
// - Reset pin fall ends deep sleep; rise restarts via reset vector.
// - Stabilization counter runs at fxx/256 or fxx/512 by select bit.
// - Clock output inhibit holds the clock output pin low.
// - Sleep request bits clear themselves when the mode ends.
// - Control writes need a preceding unlock write; misuse flags error.
// - Clock pin mode 00 is normal, 11 is inhibit, others reserved.
`timescale 1ns/1ps
`default_nettype none
module psm_power_save_ctrl #(
    parameter int unsigned STAB_TICKS = psm_pkg::STAB_TICKS
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output var  logic [31:0] o_prdata,
    output var  logic        o_pready,
    output var  logic        o_pslverr,
    input  wire logic        i_nmi_pin,
    input  wire logic        i_nmi_rising_valid,
    input  wire logic        i_reset_pin_n,
    input  wire logic        i_pll_bypass_select,
    input  wire logic        i_in_nmi_handler,
    input  wire logic        i_nmi_accepted,
    input  wire logic        i_other_store,
    input  wire logic        i_bus_hold_request,
    output var  logic        o_cpu_clk_en,
    output var  logic        o_sys_clk_en,
    output var  logic        o_osc_en,
    output var  logic        o_bus_oe,
    output var  logic        o_bus_hold_ack,
    output var  logic        o_clock_output_pin,
    output var  logic        o_nmi_pending,
    output var  logic        o_nmi_service,
    output var  logic        o_sys_reset
);
    psm_pkg::psm_state_e state_reg;
    psm_pkg::psm_state_e state_next;
    psm_pkg::psm_psc_s   psc_reg;
    logic                unlock_reg;
    logic                protection_error_flag_reg;
    logic                nmi_pend_reg;
    logic                in_nmi_reg;

    logic       wr;
    logic       setup;
    logic       psc_wr;
    logic       psc_ok;
    logic       unlock_wr;
    logic       sys_wr;
    logic       other_wr;
    logic       req_deep;
    logic       req_light;
    logic       direct;
    logic       nmi_valid;
    logic       nmi_inactive;
    logic       stab_start;
    logic       stab_done;
    logic       wake_svc;
    logic       rst_req;
    logic       run_next;
    logic       mapped;
    logic [7:0] psc_rd;

    psm_nmi_edge u_edge (
        .i_clock         (i_clock),
        .i_rst_n         (i_rst_n),
        .i_nmi_pin       (i_nmi_pin),
        .i_rising_valid  (i_nmi_rising_valid),
        .o_valid_edge    (nmi_valid),
        .o_inactive_edge (nmi_inactive)
    );

    psm_stab_counter #(
        .TICKS (STAB_TICKS)
    ) u_stab (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_start      (stab_start),
        .i_div_select (psc_reg.stabilization_divider_select),
        .o_done       (stab_done)
    );

    // Bus decode; access completes in the first access cycle
    always_comb begin
        setup     = i_psel & ~i_penable;
        wr        = i_psel & i_penable & i_pwrite & o_pready;
        psc_wr    = wr & (i_paddr == psm_pkg::PSC_OFF);
        unlock_wr = wr & (i_paddr == psm_pkg::UNLOCK_OFF);
        sys_wr    = wr & (i_paddr == psm_pkg::SYS_OFF);
        other_wr  = (wr & ~psc_wr & ~unlock_wr) | i_other_store;
        psc_ok    = psc_wr & unlock_reg;
        req_deep  = psc_ok & i_pwdata[psm_pkg::PSC_DEEP_BIT];
        req_light = psc_ok & i_pwdata[psm_pkg::PSC_LIGHT_BIT];
        mapped    = (i_paddr == psm_pkg::PSC_OFF)
                  | (i_paddr == psm_pkg::UNLOCK_OFF)
                  | (i_paddr == psm_pkg::SYS_OFF)
                  | (i_paddr == psm_pkg::STATUS_OFF);
        direct    = i_pll_bypass_select & psc_reg.external_clock_select;
        psc_rd    = {psc_reg.clk_mode, psc_reg.stabilization_divider_select, psc_reg.external_clock_select,
                     1'b0, psc_reg.light, psc_reg.deep, 1'b0};
    end

    // Sleep sequencing
    always_comb begin
        state_next = state_reg;
        wake_svc   = 1'b0;
        rst_req    = 1'b0;
        unique case (state_reg)
            psm_pkg::ST_RUN: begin
                if (req_deep) begin
                    if (nmi_pend_reg) begin
                        state_next = direct ? psm_pkg::ST_RUN
                                            : psm_pkg::ST_STAB;
                    end else begin
                        state_next = psm_pkg::ST_DEEP;
                    end
                end else if (req_light) begin
                    state_next = psm_pkg::ST_LIGHT;
                end
            end
            psm_pkg::ST_LIGHT: begin
                if (!i_reset_pin_n) begin
                    state_next = psm_pkg::ST_RST_LOW;
                end else if (nmi_valid) begin
                    state_next = psm_pkg::ST_RUN;
                    wake_svc   = ~in_nmi_reg;
                end
            end
            psm_pkg::ST_DEEP: begin
                if (!i_reset_pin_n) begin
                    state_next = psm_pkg::ST_RST_LOW;
                end else if (nmi_valid) begin
                    state_next = psm_pkg::ST_NMI_ACT;
                end
            end
            psm_pkg::ST_NMI_ACT: begin
                if (!i_reset_pin_n) begin
                    state_next = psm_pkg::ST_RST_LOW;
                end else if (nmi_inactive) begin
                    if (direct) begin
                        state_next = psm_pkg::ST_RUN;
                        wake_svc   = ~in_nmi_reg;
                    end else begin
                        state_next = psm_pkg::ST_STAB;
                    end
                end
            end
            psm_pkg::ST_STAB: begin
                if (!i_reset_pin_n) begin
                    state_next = psm_pkg::ST_RST_LOW;
                end else if (stab_done) begin
                    state_next = psm_pkg::ST_RUN;
                    wake_svc   = ~in_nmi_reg;
                end
            end
            psm_pkg::ST_RST_LOW: begin
                if (i_reset_pin_n) begin
                    state_next = psm_pkg::ST_RUN;
                    rst_req    = 1'b1;
                end
            end
            default: begin
                state_next = psm_pkg::ST_RUN;
            end
        endcase
        run_next   = state_next == psm_pkg::ST_RUN;
        stab_start = (state_next == psm_pkg::ST_STAB)
                   & (state_reg != psm_pkg::ST_STAB);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg <= psm_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Control register, written only right after an unlock
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || rst_req) begin
            psc_reg <= psm_pkg::psm_psc_s'(psm_pkg::PSC_RST[5:0]);
        end else if (psc_ok) begin
            psc_reg.clk_mode <= i_pwdata[psm_pkg::PSC_MODE_LSB +: 2];
            psc_reg.stabilization_divider_select     <= i_pwdata[psm_pkg::PSC_STABILIZATION_DIVIDER_SELECT_BIT];
            psc_reg.external_clock_select    <= i_pwdata[psm_pkg::PSC_EXTERNAL_CLOCK_SELECT_BIT];
            psc_reg.deep     <= state_next == psm_pkg::ST_DEEP;
            psc_reg.light    <= state_next == psm_pkg::ST_LIGHT;
        end else if (run_next) begin
            psc_reg.deep  <= 1'b0;
            psc_reg.light <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || rst_req) begin
            unlock_reg <= 1'b0;
        end else if (unlock_wr) begin
            unlock_reg <= 1'b1;
        end else if (psc_wr || other_wr) begin
            unlock_reg <= 1'b0;
        end
    end

    // Error set wins over a clearing write in the same cycle
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || rst_req) begin
            protection_error_flag_reg <= psm_pkg::PROTECTION_ERROR_FLAG_RST;
        end else if ((psc_wr && !unlock_reg)
                     || (unlock_reg && other_wr)) begin
            protection_error_flag_reg <= 1'b1;
        end else if (sys_wr && !i_pwdata[psm_pkg::SYS_PROTECTION_ERROR_FLAG_BIT]) begin
            protection_error_flag_reg <= 1'b0;
        end
    end

    // NMI latch; a new edge wins over acceptance
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || rst_req) begin
            nmi_pend_reg <= 1'b0;
        end else if (nmi_valid) begin
            nmi_pend_reg <= 1'b1;
        end else if (i_nmi_accepted) begin
            nmi_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            in_nmi_reg <= 1'b0;
        end else if (state_reg == psm_pkg::ST_RUN) begin
            in_nmi_reg <= i_in_nmi_handler;
        end
    end

    // Clock gates and pin drivers follow the next state
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_cpu_clk_en       <= 1'b1;
            o_sys_clk_en       <= 1'b1;
            o_osc_en           <= 1'b1;
            o_bus_oe           <= 1'b1;
            o_bus_hold_ack     <= 1'b0;
            o_clock_output_pin <= 1'b0;
        end else begin
            o_cpu_clk_en   <= run_next;
            o_sys_clk_en   <= run_next;
            o_osc_en       <= state_next != psm_pkg::ST_DEEP;
            o_bus_oe       <= run_next;
            o_bus_hold_ack <= run_next & i_bus_hold_request;
            if (run_next && psc_reg.clk_mode != psm_pkg::CLK_INHIBIT) begin
                o_clock_output_pin <= ~o_clock_output_pin;
            end else begin
                o_clock_output_pin <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_nmi_pending <= 1'b0;
            o_nmi_service <= 1'b0;
            o_sys_reset   <= 1'b0;
        end else begin
            o_nmi_pending <= nmi_pend_reg;
            o_nmi_service <= wake_svc;
            o_sys_reset   <= rst_req;
        end
    end

    // Bus slave: answer prepared in setup cycle
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & ~mapped;
            if (setup && !i_pwrite) begin
                unique case (i_paddr)
                    psm_pkg::PSC_OFF: o_prdata <= {24'h0, psc_rd};
                    psm_pkg::SYS_OFF: o_prdata <= {27'h0, protection_error_flag_reg, 4'h0};
                    psm_pkg::STATUS_OFF: begin
                        o_prdata <= {26'h0, in_nmi_reg, nmi_pend_reg,
                                     1'b0, state_reg};
                    end
                    default: o_prdata <= '0;
                endcase
            end
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    light_gate_a: assert property (
        state_reg == psm_pkg::ST_LIGHT |-> !o_cpu_clk_en && !o_sys_clk_en
            && o_osc_en)
        else $error("light sleep clocks wrong");
    light_entry_a: assert property (
        state_reg == psm_pkg::ST_RUN && req_light && !req_deep
            |=> state_reg == psm_pkg::ST_LIGHT ##1 !o_cpu_clk_en)
        else $error("light sleep not entered");
    hold_ignored_a: assert property (
        state_reg != psm_pkg::ST_RUN |-> !o_bus_hold_ack && !o_bus_oe)
        else $error("hold acknowledged while asleep");
    light_stays_a: assert property (
        state_reg == psm_pkg::ST_LIGHT && !nmi_valid && i_reset_pin_n
            |=> state_reg == psm_pkg::ST_LIGHT)
        else $error("light sleep left without cause");
    nmi_wake_a: assert property (
        state_reg == psm_pkg::ST_LIGHT && i_reset_pin_n && nmi_valid
            |=> o_nmi_service == !$past(in_nmi_reg) && o_cpu_clk_en)
        else $error("nmi wake service wrong");
    reset_wake_a: assert property (
        state_reg == psm_pkg::ST_RST_LOW && i_reset_pin_n
            |=> psc_reg == psm_pkg::psm_psc_s'(psm_pkg::PSC_RST[5:0])
            && !protection_error_flag_reg && o_sys_reset)
        else $error("reset pin wake incomplete");
    deep_osc_a: assert property (
        state_reg == psm_pkg::ST_DEEP |-> !o_osc_en && !o_sys_clk_en)
        else $error("oscillator running in deep sleep");
    direct_skip_a: assert property (
        state_reg == psm_pkg::ST_NMI_ACT && i_reset_pin_n && nmi_inactive
            && direct |=> state_reg == psm_pkg::ST_RUN)
        else $error("direct mode did not skip wait");
    stab_after_a: assert property (
        state_reg == psm_pkg::ST_NMI_ACT && i_reset_pin_n && nmi_inactive
            && !direct |=> state_reg == psm_pkg::ST_STAB)
        else $error("counter not started on inactive edge");
    inhibit_low_a: assert property (
        $past(psc_reg.clk_mode) == psm_pkg::CLK_INHIBIT
            |-> !o_clock_output_pin)
        else $error("clock pin toggles while inhibited");
    req_clear_a: assert property (
        state_reg == psm_pkg::ST_RUN && !psc_ok
            |=> !psc_reg.deep && !psc_reg.light)
        else $error("request bit not cleared");
    locked_err_a: assert property (
        psc_wr && !unlock_reg |=> protection_error_flag_reg && $stable(psc_reg.clk_mode))
        else $error("locked write not flagged");
endmodule
`default_nettype wire

// >>> hdl/psm_pkg.sv
`default_nettype none
package psm_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    localparam logic [11:0] PSC_OFF    = 12'h070;
    localparam logic [11:0] UNLOCK_OFF = 12'h074;
    localparam logic [11:0] SYS_OFF    = 12'h078;
    localparam logic [11:0] STATUS_OFF = 12'h07c;

    localparam int unsigned PSC_DEEP_BIT  = 1;
    localparam int unsigned PSC_LIGHT_BIT = 2;
    localparam int unsigned PSC_EXTERNAL_CLOCK_SELECT_BIT = 4;
    localparam int unsigned PSC_STABILIZATION_DIVIDER_SELECT_BIT  = 5;
    localparam int unsigned PSC_MODE_LSB  = 6;
    localparam int unsigned SYS_PROTECTION_ERROR_FLAG_BIT = 4;

    localparam logic [7:0] PSC_RST    = 8'h00;
    localparam logic       PROTECTION_ERROR_FLAG_RST  = 1'b0;
    localparam logic [1:0] CLK_NORMAL = 2'h0;
    localparam logic [1:0] CLK_INHIBIT = 2'h3;

    localparam int unsigned PRE_W      = 9;
    localparam int unsigned DIV_LO     = 256;
    localparam int unsigned DIV_HI     = 512;
    localparam int unsigned TICK_W     = 16;
    localparam int unsigned STAB_TICKS = 256;

    typedef struct packed {
        logic [1:0] clk_mode;
        logic       stabilization_divider_select;
        logic       external_clock_select;
        logic       light;
        logic       deep;
    } psm_psc_s;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_LIGHT,
        ST_DEEP,
        ST_NMI_ACT,
        ST_STAB,
        ST_RST_LOW
    } psm_state_e;
endpackage
`default_nettype wire

// >>> hdl/psm_nmi_edge.sv
`timescale 1ns/1ps
`default_nettype none
module psm_nmi_edge (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_nmi_pin,
    input  wire logic i_rising_valid,
    output var  logic o_valid_edge,
    output var  logic o_inactive_edge
);
    logic prev_reg;
    logic primed_reg;
    logic rise;
    logic fall;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            prev_reg   <= 1'b0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg   <= i_nmi_pin;
            primed_reg <= 1'b1;
        end
    end

    // No edge is reported before the first sample is held
    always_comb begin
        rise = primed_reg & i_nmi_pin & ~prev_reg;
        fall = primed_reg & ~i_nmi_pin & prev_reg;
        o_valid_edge    = i_rising_valid ? rise : fall;
        o_inactive_edge = i_rising_valid ? fall : rise;
    end

    edge_match_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid_edge |-> (i_nmi_pin == i_rising_valid)
            && ($past(i_nmi_pin) != i_rising_valid))
        else $error("valid edge without matching pin change");
endmodule
`default_nettype wire

// >>> hdl/psm_stab_counter.sv
`timescale 1ns/1ps
`default_nettype none
module psm_stab_counter #(
    parameter int unsigned TICKS = psm_pkg::STAB_TICKS
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_start,
    input  wire logic i_div_select,
    output var  logic o_done
);
    localparam logic [psm_pkg::PRE_W-1:0] PRE_LO =
        psm_pkg::PRE_W'(psm_pkg::DIV_LO - 1);
    localparam logic [psm_pkg::PRE_W-1:0] PRE_HI =
        psm_pkg::PRE_W'(psm_pkg::DIV_HI - 1);
    localparam logic [psm_pkg::TICK_W-1:0] LAST =
        psm_pkg::TICK_W'(TICKS - 1);

    logic [psm_pkg::PRE_W-1:0]  pre_reg;
    logic [psm_pkg::TICK_W-1:0] cnt_reg;
    logic                       busy_reg;
    logic                       sel_reg;
    logic                       tick;

    // One-cycle enable at fxx/256 or fxx/512
    assign tick = busy_reg & (pre_reg == (sel_reg ? PRE_HI : PRE_LO));

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pre_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            sel_reg  <= 1'b0;
            o_done   <= 1'b0;
        end else if (i_start) begin
            pre_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b1;
            sel_reg  <= i_div_select;
            o_done   <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (tick) begin
                pre_reg <= '0;
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg == LAST) begin
                    busy_reg <= 1'b0;
                    o_done   <= 1'b1;
                end
            end else if (busy_reg) begin
                pre_reg <= pre_reg + 1'b1;
            end
        end
    end

    div_period_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        tick && !i_start |=> pre_reg == '0)
        else $error("prescaler not restarted after tick");
endmodule
`default_nettype wire

// >>> verif/psm_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module psm_far_side (
    input  wire logic i_clock,
    output var  logic o_nmi_pin,
    output var  logic o_reset_pin_n
);
    // Falling edge is the valid edge, so the pin idles high
    initial begin
        o_nmi_pin     = 1'b1;
        o_reset_pin_n = 1'b1;
    end

    // Oscillator input is always running, long before any wake
    task automatic nmi_pulse(input int w);
        @(posedge i_clock);
        o_nmi_pin <= 1'b0;
        repeat (w) @(posedge i_clock);
        o_nmi_pin <= 1'b1;
    endtask

    task automatic reset_pulse(input int w);
        @(posedge i_clock);
        o_reset_pin_n <= 1'b0;
        repeat (w) @(posedge i_clock);
        o_reset_pin_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> verif/test_psm_power_save_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_psm_power_save_ctrl;
    localparam int TK = 2;
    logic        i_clock, i_rst_n, psel, pen, pwr, byp, inh, acc, ost, hrq;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, q;
    logic        rdy, slv, cpu, sys, osc, boe, hak, ckp, pnd, svc, srs;
    logic        nmi, rpin;
    int          err_total, samples_checked, cyc, nsvc, nrst, m_ctrl, n, k;
    int          seed;

    psm_power_save_ctrl #(.STAB_TICKS(TK)) u_psm_power_save_ctrl (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(slv), .i_nmi_pin(nmi),
        .i_nmi_rising_valid(1'b0), .i_reset_pin_n(rpin),
        .i_pll_bypass_select(byp), .i_in_nmi_handler(inh),
        .i_nmi_accepted(acc), .i_other_store(ost),
        .i_bus_hold_request(hrq), .o_cpu_clk_en(cpu), .o_sys_clk_en(sys),
        .o_osc_en(osc), .o_bus_oe(boe), .o_bus_hold_ack(hak),
        .o_clock_output_pin(ckp), .o_nmi_pending(pnd),
        .o_nmi_service(svc), .o_sys_reset(srs));
    psm_far_side u_psm_far_side (
        .i_clock(i_clock), .o_nmi_pin(nmi), .o_reset_pin_n(rpin));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cyc++;
        if (svc === 1'b1) nsvc++;
        if (srs === 1'b1) nrst++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge i_clock);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
        @(posedge i_clock);
        pen <= 1'b1;
        do begin
            @(posedge i_clock);
            t++;
        end while (rdy !== 1'b1 && t < 20);
        q = prd;
        psel <= 1'b0; pen <= 1'b0;
    endtask

    task automatic prog(input int d);
        apb(1'b1, psm_pkg::UNLOCK_OFF, $random(seed));
        apb(1'b1, psm_pkg::PSC_OFF, 32'(d));
        m_ctrl = d & 8'hf0;
        repeat (3) @(posedge i_clock);
    endtask

    task automatic wait_run();
        n = 0;
        while (sys !== 1'b1 && n < 3000) begin
            @(posedge i_clock);
            n++;
        end
        repeat (3) @(posedge i_clock);
    endtask

    // CPU takes the pending NMI; pending output lags by two edges
    task automatic accept();
        acc <= 1'b1;
        @(posedge i_clock);
        acc <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        seed = 32'hfbbf2c8c;
        {err_total, samples_checked, cyc, nsvc, nrst, m_ctrl} = '0;
        {psel, pen, pwr, byp, inh, acc, ost, hrq} = '0;
        paddr = 12'h000; pwd = 32'h0000_0000; i_rst_n = 1'b0;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        hrq <= 1'b1;
        apb(1'b0, psm_pkg::STATUS_OFF, 0); chk("status", q, 0);
        chk("hold_ack", hak, 1);
        apb(1'b1, psm_pkg::PSC_OFF, 32'h04);
        apb(1'b0, psm_pkg::PSC_OFF, 0); chk("locked", q, 0);
        apb(1'b0, psm_pkg::SYS_OFF, 0); chk("protection_error_flag", q, 32'h10);
        apb(1'b1, psm_pkg::SYS_OFF, 0);
        apb(1'b0, psm_pkg::SYS_OFF, 0); chk("protection_error_flag_clr", q, 0);
        apb(1'b0, 12'h100 + 12'({$random(seed)} % 64 * 4), 0);
        chk("unmapped_err", slv, 1);
        chk("unmapped", q, 0);
        for (k = 0; k < 2; k++) begin
            inh <= k[0];
            prog(32'h04);
            chk("light", {cpu, sys, osc, boe, hak, ckp}, 6'b001000);
            ost <= 1'b1;
            @(posedge i_clock);
            ost <= 1'b0;
            repeat (4) @(posedge i_clock);
            chk("no_wake", sys, 0);
            u_psm_far_side.nmi_pulse(3);
            wait_run();
            chk("svc", nsvc, 1);
            if (!k[0]) accept();
            chk("pend", pnd, k[0]);
        end
        acc <= 1'b1; inh <= 1'b0;
        @(posedge i_clock);
        acc <= 1'b0;
        apb(1'b0, psm_pkg::PSC_OFF, 0); chk("ctrl", q, m_ctrl);
        for (k = 0; k < 3; k++) begin
            byp <= (k == 2);
            prog(k == 2 ? 32'h12 : k == 1 ? 32'h22 : 32'h02);
            chk("deep", {cpu, sys, osc, boe, ckp}, 5'b00000);
            u_psm_far_side.nmi_pulse(6);
            wait_run();
            chk("stab", n >= (k == 2 ? 0 : TK * 256 * (k + 1)), 1);
            chk("stab_max", n <= (k == 2 ? 6 : TK * 256 * (k + 1) + 6), 1);
            chk("nmi_vec", nsvc, k + 2);
            chk("pend_wake", pnd, 1);
            accept();
            apb(1'b0, psm_pkg::PSC_OFF, 0); chk("ctrl", q, m_ctrl);
        end
        u_psm_far_side.nmi_pulse(2);
        repeat (2) @(posedge i_clock);
        prog(32'h12);
        chk("pend_deep", sys, 1);
        acc <= 1'b1;
        @(posedge i_clock);
        acc <= 1'b0;
        prog(32'h02);
        u_psm_far_side.reset_pulse(20);
        wait_run();
        chk("rst", nrst, 1);
        apb(1'b0, psm_pkg::PSC_OFF, 0); chk("rst_ctrl", q, 0);
        for (k = 0; k < 4; k++) begin
            prog(k << 6);
            n = 0;
            repeat (4) begin
                @(posedge i_clock);
                n += ckp;
            end
            chk("clock_output_pin", n, k == 3 ? 0 : 2);
        end
        chk("inhibit", ckp, 0);
        results();
    end
endmodule
`default_nettype wire
